// File: conv_seq.sv
// Conversion start sequencer: acquisition timing, conversion, result readout.
// Host bus is a plain synchronous port; trigger pin is three signals.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none

module conv_seq #(
  parameter int CONV_LEN = conv_seq_pkg::CONV_CYCLES,
  parameter int CAL_LEN = conv_seq_pkg::CAL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [12:0] sample_in,
  input wire logic trig_in,
  output logic trig_out,
  output logic trig_oe_n,
  output logic conversion_ready_n
);

  // Current configuration bundle
  conv_seq_pkg::cfg_t cfg;
  // Sequencer state
  conv_seq_pkg::state_t state;
  // Cycle counter shared by acquisition, conversion and calibration
  logic [7:0] cnt;
  // Held result and the sample latched at hold time
  logic [12:0] result;
  logic [12:0] held;
  // Byte pointer for 8-bit reads: set after the low byte
  logic byte_hi;
  // Previous trigger level for edge detection
  logic trig_q;

  // Acquisition count lookup from the select bits
  function automatic logic [6:0] acq_len(input logic [1:0] sel);
    case (sel)
      2'h0: acq_len = conv_seq_pkg::ACQ_CNT0;
      2'h1: acq_len = conv_seq_pkg::ACQ_CNT1;
      2'h2: acq_len = conv_seq_pkg::ACQ_CNT2;
      default: acq_len = conv_seq_pkg::ACQ_CNT3;
    endcase
  endfunction

  // Bus decode
  wire cfg_wr = wr && (addr == conv_seq_pkg::OFS_CFG);
  wire data_rd = rd && (addr == conv_seq_pkg::OFS_DATA);
  wire [2:0] new_cmd = wdata[conv_seq_pkg::CMD_LSB +: conv_seq_pkg::CMD_W];
  wire trig_rise = trig_in && !trig_q;
  // A read that completes the result: second byte, or any 13-bit read
  wire last_rd = data_rd && (cfg.bus_width_bit || byte_hi);
  wire is_async = !cfg.trig_mode;
  wire start_cfg = (cfg.cmd == conv_seq_pkg::CMD_START);
  wire [7:0] acq_end = {1'b0, acq_len(cfg.acquisition_select_bits)} - 8'h01;
  wire [7:0] conv_end = 8'(CONV_LEN - 1);
  wire [7:0] cal_end = 8'(CAL_LEN - 1);
  wire [15:0] next_rdata = (addr == conv_seq_pkg::OFS_CFG) ? {9'h000, cfg} :
    (addr == conv_seq_pkg::OFS_STATUS) ? {10'h000, state} :
    !data_rd ? 16'h0000 :
    cfg.bus_width_bit ? {{3{result[12]}}, result} :
    byte_hi ? {11'h000, result[12:8]} : {8'h00, result[7:0]};

  // Configuration register: reset puts standby and sync mode in place
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg <= conv_seq_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg <= wdata[conv_seq_pkg::CFG_W-1:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rd ? next_rdata : 16'h0000;
    end
  end

  // Byte pointer: low byte first, a configuration write rewinds it
  always_ff @(posedge sys_clk) begin
    if (rst || cfg_wr) begin
      byte_hi <= 1'b0;
    end else if (data_rd && !cfg.bus_width_bit) begin
      byte_hi <= !byte_hi;
    end
  end

  // Trigger edge detector; pin is an input only in sync mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_in;
    end
  end

  // Main sequencer; a command write outranks any activity in progress
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= conv_seq_pkg::ST_STANDBY;
      cnt <= 8'h00;
      conversion_ready_n <= 1'b1;
      trig_out <= 1'b0;
      trig_oe_n <= 1'b1;
      result <= 13'h0000;
      held <= 13'h0000;
    end else if (cfg_wr) begin
      trig_out <= 1'b0;
      trig_oe_n <= wdata[conv_seq_pkg::TRIG_MODE_BIT];
      cnt <= 8'h00;
      case (new_cmd)
        conv_seq_pkg::CMD_STANDBY: begin
          state <= conv_seq_pkg::ST_STANDBY;
          conversion_ready_n <= 1'b1;
        end
        conv_seq_pkg::CMD_FULCAL, conv_seq_pkg::CMD_AUTOZERO: begin
          state <= conv_seq_pkg::ST_CAL;
          conversion_ready_n <= 1'b1;
        end
        default: begin
          // Start and reset both land in the ready state with ready_n low
          state <= conv_seq_pkg::ST_READY;
          conversion_ready_n <= 1'b0;
        end
      endcase
    end else begin
      case (state)
        conv_seq_pkg::ST_STANDBY: begin
          conversion_ready_n <= 1'b1;
        end
        conv_seq_pkg::ST_READY: begin
          if (start_cfg && is_async && last_rd) begin
            state <= conv_seq_pkg::ST_ACQ;
            conversion_ready_n <= 1'b1;
            cnt <= 8'h00;
          end else if (start_cfg && !is_async && trig_rise) begin
            // Trigger holds the input and converts at once
            state <= conv_seq_pkg::ST_CONV;
            conversion_ready_n <= 1'b1;
            held <= sample_in;
            cnt <= 8'h00;
          end else if (start_cfg && !is_async && last_rd) begin
            // Read only raises ready_n; tracking continues to the trigger
            state <= conv_seq_pkg::ST_TRACK;
            conversion_ready_n <= 1'b1;
          end
        end
        conv_seq_pkg::ST_ACQ: begin
          if (cnt == acq_end) begin
            state <= conv_seq_pkg::ST_CONV;
            trig_out <= 1'b1;
            held <= sample_in;
            cnt <= 8'h00;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        conv_seq_pkg::ST_TRACK: begin
          if (trig_rise) begin
            state <= conv_seq_pkg::ST_CONV;
            held <= sample_in;
            cnt <= 8'h00;
          end
        end
        conv_seq_pkg::ST_CONV: begin
          if (cnt == conv_end) begin
            state <= conv_seq_pkg::ST_READY;
            conversion_ready_n <= 1'b0;
            trig_out <= 1'b0;
            result <= held;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        conv_seq_pkg::ST_CAL: begin
          // Calibration internals are outside this block; only its length is timed
          if (cnt == cal_end) begin
            state <= conv_seq_pkg::ST_READY;
            conversion_ready_n <= 1'b0;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          state <= conv_seq_pkg::ST_STANDBY;
        end
      endcase
    end
  end

  // Async 13-bit read from ready raises ready_n on the next edge
  property p_read_raises;
    @(posedge sys_clk) disable iff (rst)
      (state == conv_seq_pkg::ST_READY && start_cfg && is_async && cfg.bus_width_bit && data_rd && !wr)
        |=> conversion_ready_n && state == conv_seq_pkg::ST_ACQ;
  endproperty
  a_read_raises: assert property (p_read_raises) else $error("read did not start acquisition");

  // Status pin rises exactly after the count for select code 0; a command write abandons the check
  property p_acq_len;
    @(posedge sys_clk) disable iff (rst || cfg_wr)
      ($rose(state == conv_seq_pkg::ST_ACQ) && cfg.acquisition_select_bits == 2'h0)
        |-> !trig_out [*8] ##1 !trig_out ##1 trig_out;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition length wrong");

  // Status pin only high while converting in async mode
  property p_status_conv;
    @(posedge sys_clk) disable iff (rst)
      trig_out |-> state == conv_seq_pkg::ST_CONV && !trig_oe_n;
  endproperty
  a_status_conv: assert property (p_status_conv) else $error("status pin outside conversion");

  // End of conversion drops both ready_n and the status pin
  property p_done;
    @(posedge sys_clk) disable iff (rst)
      (state == conv_seq_pkg::ST_CONV && cnt == conv_end && !cfg_wr) |=> !conversion_ready_n && !trig_out;
  endproperty
  a_done: assert property (p_done) else $error("conversion end not signalled");

  // In sync mode nothing but a trigger edge enters conversion
  property p_sync_trig;
    @(posedge sys_clk) disable iff (rst)
      (!is_async && !cfg_wr && state != conv_seq_pkg::ST_CONV) ##1 (state == conv_seq_pkg::ST_CONV)
        |-> $past(trig_rise);
  endproperty
  a_sync_trig: assert property (p_sync_trig) else $error("sync conversion without trigger");

  // Standby holds ready_n high
  property p_standby;
    @(posedge sys_clk) disable iff (rst)
      state == conv_seq_pkg::ST_STANDBY |-> conversion_ready_n;
  endproperty
  a_standby: assert property (p_standby) else $error("ready_n low in standby");

  // Reset command lands in ready with ready_n low
  property p_reset_cmd;
    @(posedge sys_clk) disable iff (rst)
      (cfg_wr && new_cmd == conv_seq_pkg::CMD_RESET) |=> state == conv_seq_pkg::ST_READY && !conversion_ready_n;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command failed");

  // 8-bit first read gives the low byte, second the high byte
  property p_bytes;
    @(posedge sys_clk) disable iff (rst)
      (data_rd && !cfg.bus_width_bit && !byte_hi) |=> rdata == {8'h00, $past(result[7:0])};
  endproperty
  a_bytes: assert property (p_bytes) else $error("low byte not first");

  // 8-bit second read gives the upper bits of the result
  property p_high_byte;
    @(posedge sys_clk) disable iff (rst)
      (data_rd && !cfg.bus_width_bit && byte_hi) |=> rdata == {11'h000, $past(result[12:8])};
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte not second");

  // 13-bit read returns the whole result, sign extended
  property p_word_read;
    @(posedge sys_clk) disable iff (rst)
      (data_rd && cfg.bus_width_bit) |=> rdata == {{3{$past(result[12])}}, $past(result)};
  endproperty
  a_word_read: assert property (p_word_read) else $error("whole result not returned");

  // Async 8-bit: the second read starts acquisition
  property p_async8_start;
    @(posedge sys_clk) disable iff (rst)
      (state == conv_seq_pkg::ST_READY && start_cfg && is_async && !cfg.bus_width_bit && data_rd && byte_hi && !wr)
        |=> conversion_ready_n && state == conv_seq_pkg::ST_ACQ;
  endproperty
  a_async8_start: assert property (p_async8_start) else $error("second read did not restart");

  // Async 8-bit: the first read alone starts nothing
  property p_first_byte_wait;
    @(posedge sys_clk) disable iff (rst)
      (state == conv_seq_pkg::ST_READY && is_async && !cfg.bus_width_bit && data_rd && !byte_hi && !wr)
        |=> state == conv_seq_pkg::ST_READY && !conversion_ready_n;
  endproperty
  a_first_byte_wait: assert property (p_first_byte_wait) else $error("first read left ready");

  // Sync mode: a completing read only raises ready_n and waits for the trigger
  property p_sync_read;
    @(posedge sys_clk) disable iff (rst)
      (state == conv_seq_pkg::ST_READY && start_cfg && !is_async && last_rd && !trig_rise && !wr)
        |=> conversion_ready_n && state == conv_seq_pkg::ST_TRACK;
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("sync read did not raise ready_n");

  // Tracking lasts until a trigger edge or a command write
  property p_track_hold;
    @(posedge sys_clk) disable iff (rst)
      (state == conv_seq_pkg::ST_TRACK && !trig_rise && !cfg_wr) |=> state == conv_seq_pkg::ST_TRACK && conversion_ready_n;
  endproperty
  a_track_hold: assert property (p_track_hold) else $error("tracking ended without trigger");

  // Pin drives only in async mode; direction follows the mode bit
  property p_pin_dir;
    @(posedge sys_clk) disable iff (rst)
      trig_oe_n == cfg.trig_mode;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction disagrees with mode");

  // A start command write lands in ready with ready_n low
  property p_start_cmd;
    @(posedge sys_clk) disable iff (rst)
      (cfg_wr && new_cmd == conv_seq_pkg::CMD_START) |=> state == conv_seq_pkg::ST_READY && !conversion_ready_n;
  endproperty
  a_start_cmd: assert property (p_start_cmd) else $error("start command not taken");

  // Ready_n stays high until the conversion count runs out
  property p_conv_busy;
    @(posedge sys_clk) disable iff (rst)
      (state == conv_seq_pkg::ST_CONV && cnt != conv_end && !cfg_wr) |=> state == conv_seq_pkg::ST_CONV && conversion_ready_n;
  endproperty
  a_conv_busy: assert property (p_conv_busy) else $error("conversion ended early");

endmodule // conv_seq

`default_nettype wire

// File: conv_seq_pkg.sv
// Shared constants and carriers for the conversion start sequencer.
// Assumes a single 125 MHz system clock and a synchronous active-high reset.
package conv_seq_pkg;

  // Configuration word layout (written by the host in one strobe)
  localparam int ACQ_SEL_LSB = 0;
  localparam int ACQ_SEL_W = 2;
  localparam int CMD_LSB = 4;
  localparam int CMD_W = 3;
  localparam int TRIG_MODE_BIT = 2;
  localparam int BUS_WIDTH_BIT = 3;
  localparam int CFG_W = 7;

  // Command codes in the command field
  localparam logic [2:0] CMD_START = 3'h0;
  localparam logic [2:0] CMD_STANDBY = 3'h1;
  localparam logic [2:0] CMD_RESET = 3'h2;
  localparam logic [2:0] CMD_FULCAL = 3'h3;
  localparam logic [2:0] CMD_AUTOZERO = 3'h4;

  // Register offsets on the plain port
  localparam logic [1:0] OFS_CFG = 2'h0;
  localparam logic [1:0] OFS_DATA = 2'h1;
  localparam logic [1:0] OFS_STATUS = 2'h2;

  // Reset value: standby command, synchronous trigger mode, 8-bit bus
  localparam logic [6:0] CFG_RESET = 7'h14;

  // Acquisition counts in master clock cycles for each select code
  localparam logic [6:0] ACQ_CNT0 = 7'h09;
  localparam logic [6:0] ACQ_CNT1 = 7'h0F;
  localparam logic [6:0] ACQ_CNT2 = 7'h2F;
  localparam logic [6:0] ACQ_CNT3 = 7'h4F;

  // Default conversion and calibration lengths in cycles
  localparam int CONV_CYCLES = 44;
  localparam int CAL_CYCLES = 200;

  localparam int RESULT_W = 13;

  // Decoded configuration carried as one bundle
  typedef struct packed {
    logic [2:0] cmd;
    logic bus_width_bit;
    logic trig_mode;
    logic [1:0] acquisition_select_bits;
  } cfg_t;

  typedef enum logic [5:0] {
    ST_STANDBY = 6'h01,
    ST_READY = 6'h02,
    ST_ACQ = 6'h04,
    ST_TRACK = 6'h08,
    ST_CONV = 6'h10,
    ST_CAL = 6'h20
  } state_t;

endpackage

// File: conv_seq_trig_model.sv
// Far-side trigger source: a steady train of pulses on the trigger pin.
// Assumes the bench enables it only while the block is in the synchronous mode.
`timescale 1ns/1ns
`default_nettype none
module trig_source #(
  parameter int PERIOD = 64,
  parameter int HIGH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic en,
  output logic trig
);
  int cnt; // Phase within one pulse period
  // Pulse train runs while enabled; idle low so no stray edge appears
  always_ff @(posedge sys_clk) begin
    if (rst || !en) begin
      cnt <= 0;
      trig <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      trig <= (cnt < HIGH);
    end
  end
endmodule // trig_source
`default_nettype wire

// File: adc_conversion_start_sequencer_tb.sv
// Self-checking bench for the conversion start sequencer.
// Assumes short conversion and calibration lengths passed as parameters.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module adc_conversion_start_sequencer_tb;
  localparam int CONV = 4; // Short conversion keeps the run brief
  localparam int CAL = 20; // Calibration long enough to abort it part way
  logic sys_clk = 0, rst = 1, wr = 0, rd = 0, trig_en = 0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic [12:0] sample_in = 13'h1A5C;
  logic trig_in, trig_out, trig_oe_n, conversion_ready_n;
  int failures = 0, samples_checked = 0, cyc = 0, n;
  logic [6:0] acq [4]; // Expected acquisition counts per select code
  conv_seq #(.CONV_LEN(CONV), .CAL_LEN(CAL)) uut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sample_in(sample_in), .trig_in(trig_in), .trig_out(trig_out),
    .trig_oe_n(trig_oe_n), .conversion_ready_n(conversion_ready_n));
  trig_source #(.PERIOD(64), .HIGH(8)) host_trig (.sys_clk(sys_clk), .rst(rst), .en(trig_en), .trig(trig_in));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // Hang guard: generous ceiling over the whole sequence
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr_cfg(input logic [7:0] v);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= conv_seq_pkg::OFS_CFG;
    wdata <= {8'h00, v};
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Count cycles until ready (s=0) or status pin (s=1) reaches v
  task automatic wt(input int s, input logic v, output int c);
    c = 0;
    #1;
    while (((s == 0) ? conversion_ready_n : trig_out) !== v && c < 600) begin
      @(posedge sys_clk);
      #1 c++;
    end
    `CHK("wait bound", 1'b1, c < 600)
  endtask
  task automatic t_power_up();
    rd_reg(2'h2, d);
    `CHK("standby state", 16'h0001, d)
    `CHK("pin is input", 1'b1, trig_oe_n)
    `CHK("standby ready", 1'b1, conversion_ready_n)
    $display("test power_up done");
  endtask
  task automatic t_async8();
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      sample_in <= 13'h1A5C ^ 13'(s);
      wr_cfg(8'(s));
      wt(0, 1'b0, n);
      rd_reg(2'h1, d);
      rd_reg(2'h1, d);
      wt(0, 1'b1, n);
      `CHK("raise after read2", 1'b1, n <= 2)
      wt(1, 1'b1, n);
      `CHK("acq count", int'(acq[s]), n)
      `CHK("pin driven", 1'b0, trig_oe_n)
      wt(0, 1'b0, n);
      `CHK("conv length", CONV, n)
      `CHK("pin low at done", 1'b0, trig_out)
      rd_reg(2'h1, d);
      `CHK("low byte", 8'h5C ^ 8'(s), d[7:0])
      rd_reg(2'h1, d);
      `CHK("high byte", 5'h1A, d[4:0])
      wt(0, 1'b1, n);
      `CHK("restart", 1'b1, n <= 2)
    end
    $display("test async8 done");
  endtask
  task automatic t_async13();
    @(posedge sys_clk);
    sample_in <= 13'h1A5C;
    wr_cfg(8'h0B);
    wt(0, 1'b0, n);
    rd_reg(2'h1, d);
    wt(0, 1'b1, n);
    `CHK("single read start", 1'b1, n <= 2)
    wt(1, 1'b1, n);
    `CHK("acq count 79", 79, n)
    wt(0, 1'b0, n);
    rd_reg(2'h1, d);
    `CHK("whole result", 16'hFA5C, d)
    wt(0, 1'b1, n);
    `CHK("restart 13", 1'b1, n <= 2)
    $display("test async13 done");
  endtask
  task automatic t_sync();
    @(posedge sys_clk);
    sample_in <= 13'h0123;
    wr_cfg(8'h07);
    wt(0, 1'b0, n);
    // Host raises ready_n by reading, before any trigger
    rd_reg(2'h1, d);
    rd_reg(2'h1, d);
    wt(0, 1'b1, n);
    `CHK("read raises", 1'b1, n <= 2)
    repeat (100) @(posedge sys_clk);
    #1 `CHK("no conv by read", 1'b1, conversion_ready_n)
    `CHK("pin input", 1'b1, trig_oe_n)
    trig_en <= 1'b1;
    wt(0, 1'b0, n);
    trig_en <= 1'b0;
    rd_reg(2'h1, d);
    `CHK("sync low", 8'h23, d[7:0])
    rd_reg(2'h1, d);
    `CHK("sync high", 5'h01, d[4:0])
    wr_cfg(8'h0C);
    wt(0, 1'b0, n);
    `CHK("new cmd taken", 1'b1, n <= 2)
    trig_en <= 1'b1;
    wt(0, 1'b1, n);
    `CHK("trigger raises", 1'b1, n < 80)
    wt(0, 1'b0, n);
    trig_en <= 1'b0;
    rd_reg(2'h1, d);
    `CHK("sync whole", 16'h0123, d)
    wt(0, 1'b1, n);
    `CHK("read raises 13", 1'b1, n <= 2)
    $display("test sync done");
  endtask
  task automatic t_commands();
    wr_cfg(8'h0B);
    rd_reg(2'h1, d);
    // Abort while the status pin is up, in the middle of a conversion
    wt(1, 1'b1, n);
    wr_cfg(8'h28);
    wt(0, 1'b0, n);
    `CHK("reset aborts", 1'b1, n <= 2)
    `CHK("pin drops", 1'b0, trig_out)
    rd_reg(2'h2, d);
    `CHK("ready state", 16'h0002, d)
    wr_cfg(8'h18);
    wt(0, 1'b1, n);
    rd_reg(2'h2, d);
    `CHK("standby", 16'h0001, d)
    wr_cfg(8'h20);
    wt(0, 1'b0, n);
    `CHK("reset exits standby", 1'b1, n <= 2)
    // Full calibration holds ready_n high for its whole length
    wr_cfg(8'h30);
    #1 `CHK("cal busy", 1'b1, conversion_ready_n)
    wt(0, 1'b0, n);
    `CHK("cal length", CAL, n)
    // Auto-zero cut short by a reset command
    wr_cfg(8'h40);
    wr_cfg(8'h20);
    wt(0, 1'b0, n);
    `CHK("reset aborts cal", 1'b1, n <= 2)
    rd_reg(2'h3, d);
    `CHK("unmapped", 16'h0000, d)
    $display("test commands done");
  endtask
  initial begin
    acq = '{conv_seq_pkg::ACQ_CNT0, conv_seq_pkg::ACQ_CNT1, conv_seq_pkg::ACQ_CNT2, conv_seq_pkg::ACQ_CNT3};
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_power_up();
    t_async8();
    t_async13();
    t_sync();
    t_commands();
    report_and_stop();
  end
endmodule // adc_conversion_start_sequencer_tb
`default_nettype wire
